// [hdl/dasc_top.v]
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dasc_consts.vh"
module dasc_top (
   // Clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // Serial control pins
   input wire ser_clk_i,
   input wire ser_data_in_i,
   input wire out_atten_strobe_i,
   input wire in_atten_strobe_i,
   input wire word_order_sel_i,
   input wire init_state_sel_a_i,
   input wire init_state_sel_b_i,
   output reg ser_data_out_o,
   // Attenuator states
   output reg [5:0] out_atten_ctrl_bits_o,
   output reg [5:0] in_atten_ctrl_bits_o,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o
);
////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [5:0] sync1_reg;
reg [5:0] sync2_reg;
reg sclk_d_reg;
reg oes_d_reg;
reg ies_d_reg;
// Chain keeps tracking the pins in reset, so power-up selects are valid at release
always @(posedge core_clk_i) begin
   sync1_reg <= {init_state_sel_b_i, init_state_sel_a_i, word_order_sel_i,
                 in_atten_strobe_i, out_atten_strobe_i, ser_clk_i};
   sync2_reg <= sync1_reg;
   // Edge history follows the pins in reset: no false edge after release
   sclk_d_reg <= sync2_reg[0];
   oes_d_reg <= sync2_reg[1];
   ies_d_reg <= sync2_reg[2];
end
reg sdat1_reg;
reg sdat2_reg;
always @(posedge core_clk_i) begin
   if (!rst_n_i) begin
      sdat1_reg <= 1'b0;
      sdat2_reg <= 1'b0;
   end else begin
      sdat1_reg <= ser_data_in_i;
      sdat2_reg <= sdat1_reg;
   end
end
wire sclk_rise = sync2_reg[0] & ~sclk_d_reg;
wire oes_rise = sync2_reg[1] & ~oes_d_reg;
wire ies_rise = sync2_reg[2] & ~ies_d_reg;
wire msb_first = sync2_reg[3];
////////////////////////////////////////////////////////////////////////////////
// Shift register and word assembly
reg [7:0] shift_reg;
reg [3:0] bit_cnt_reg;
reg init_done_reg;
reg [31:0] ctrl_reg;
wire [7:0] word_le;
genvar gi;
generate
   for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
      assign word_le[gi] = shift_reg[7 - gi];
   end
endgenerate
// MSB first: first bit ends at bit 7; LSB first: first bit ends at bit 0
wire [7:0] word_val = msb_first ? shift_reg : word_le;
wire ctrl_force_max = ctrl_reg[0];
always @(posedge core_clk_i) begin
   if (!rst_n_i) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ser_data_out_o <= 1'b0;
      out_atten_ctrl_bits_o <= `DASC_ATTEN_FULL;
      in_atten_ctrl_bits_o <= `DASC_ATTEN_FULL;
      init_done_reg <= 1'b0;
   end else begin
      if (sclk_rise) begin
         shift_reg <= {shift_reg[6:0], sdat2_reg};
         ser_data_out_o <= shift_reg[7];
         if (bit_cnt_reg != 4'h8)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (!init_done_reg) begin
         init_done_reg <= 1'b1;
         if (!sync2_reg[1] && !sync2_reg[2]) begin
            if (sync2_reg[4] && sync2_reg[5]) begin
               out_atten_ctrl_bits_o <= `DASC_ATTEN_MAX_GAIN;
               in_atten_ctrl_bits_o <= `DASC_ATTEN_MAX_GAIN;
            end
         end
      end else if (ctrl_force_max) begin
         out_atten_ctrl_bits_o <= `DASC_ATTEN_MAX_GAIN;
         in_atten_ctrl_bits_o <= `DASC_ATTEN_MAX_GAIN;
      end else begin
         // Low bit inserts its step, all high is 0 dB
         if (oes_rise)
            out_atten_ctrl_bits_o <= word_val[5:0];
         if (ies_rise)
            in_atten_ctrl_bits_o <= word_val[5:0];
      end
      if (init_done_reg && !ctrl_force_max && (oes_rise || ies_rise))
         bit_cnt_reg <= sclk_rise ? 4'h1 : 4'h0;
   end
end
////////////////////////////////////////////////////////////////////////////////
// Wishbone slave
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
always @(posedge core_clk_i) begin
   if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_reg <= 32'h00000000;
   end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_adr_i == `DASC_WB_ADDR_CTRL && wb_sel_i[0])
         ctrl_reg <= {31'h00000000, wb_dat_i[0]};
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            `DASC_WB_ADDR_STATUS:
               wb_dat_o <= {16'h0000, 2'h0, in_atten_ctrl_bits_o,
                            2'h0, out_atten_ctrl_bits_o};
            `DASC_WB_ADDR_CTRL:
               wb_dat_o <= ctrl_reg;
            `DASC_WB_ADDR_SHIFT:
               wb_dat_o <= {19'h00000, msb_first, bit_cnt_reg, word_val};
            default:
               wb_dat_o <= 32'h00000000;
         endcase
      end
   end
end
endmodule
`default_nettype wire

// [hdl/dasc_consts.vh]
`ifndef DASC_CONSTS_VH
`define DASC_CONSTS_VH
`define DASC_WORD_W 8
`define DASC_ATTEN_W 6
`define DASC_CNT_W 4
`define DASC_ATTEN_MAX_GAIN 6'h3f
`define DASC_ATTEN_FULL 6'h00
`define DASC_WB_ADDR_STATUS 4'h0
`define DASC_WB_ADDR_CTRL 4'h4
`define DASC_WB_ADDR_SHIFT 4'h8
`endif

// [tb/dasc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module dasc_chk (
   input wire logic core_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_ack_o,
   input wire logic out_atten_strobe_i, in_atten_strobe_i,
   input wire logic [5:0] out_atten_ctrl_bits_o, in_atten_ctrl_bits_o);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   ack_single_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing");
   ack_idle_a: assert property (!wb_cyc_i |-> !wb_ack_o)
      else $error("ack without cycle");
   out_load_a: assert property ($changed(out_atten_ctrl_bits_o) |->
      !$past(rst_n_i, 2) || $past(out_atten_strobe_i, 3) || $past(wb_cyc_i, 2))
      else $error("output attenuator changed without strobe");
   in_load_a: assert property ($changed(in_atten_ctrl_bits_o) |->
      !$past(rst_n_i, 2) || $past(in_atten_strobe_i, 3) || $past(wb_cyc_i, 2))
      else $error("input attenuator changed without strobe");
   reset_state_a: assert property (disable iff (1'b0) !rst_n_i |=>
      (out_atten_ctrl_bits_o | in_atten_ctrl_bits_o) == 6'h00) else $error("reset state");
   state_hold_a: assert property ((!out_atten_strobe_i && !in_atten_strobe_i &&
      !wb_cyc_i) [*6] |=> $stable({out_atten_ctrl_bits_o, in_atten_ctrl_bits_o}))
      else $error("state changed");
endmodule
bind dasc_top dasc_chk u_chk (.*);
`default_nettype wire

// [tb/dasc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module dasc_host (input wire logic clk, output logic sck = 0, sdi = 0, so = 0, si = 0);
   task automatic shift_word(input logic [7:0] w);
      for (int i = 7; i >= 0; i--) begin
         sdi <= w[i];
         repeat (4) @(posedge clk);
         sck <= 1;
         repeat (4) @(posedge clk);
         sck <= 0;
      end
      sdi <= ~w[0];
   endtask
   task automatic latch(input logic a, b);
      repeat (4) @(posedge clk);
      {so, si} <= {a, b};
      repeat (4) @(posedge clk);
      {so, si} <= 2'b00;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic c = 0, rst_n_i = 0, init_state_sel_a_i = 1, init_state_sel_b_i = 1;
   logic word_order_sel_i = 1, wb_cyc_i = 0, wb_we_i = 0;
   logic [3:0] wb_adr_i = 0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 0, rd;
   logic [5:0] e, p = 0;
   wire ser_clk_i, ser_data_in_i, out_atten_strobe_i, in_atten_strobe_i, ser_data_out_o, wb_ack_o;
   wire core_clk_i = c;
   wire wb_stb_i = wb_cyc_i;
   wire [5:0] out_atten_ctrl_bits_o, in_atten_ctrl_bits_o;
   wire [31:0] wb_dat_o;
   wire [11:0] att = {in_atten_ctrl_bits_o, out_atten_ctrl_bits_o};
   int errors = 0, compares = 0;
   dasc_top u_dut (.*);
   dasc_host u_host (.clk(c), .sck(ser_clk_i), .sdi(ser_data_in_i),
      .so(out_atten_strobe_i), .si(in_atten_strobe_i));
   task automatic chk(string n, logic [31:0] x, s);
      compares++;
      if (s !== x) begin errors++; $display("ERROR %s exp %h seen %h", n, x, s); end
   endtask
   task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
      {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, we, a, d};
      do @(posedge c); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      @(posedge c);
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_init();
      chk("att", 12'hfff, att);
      {rst_n_i, init_state_sel_a_i, init_state_sel_b_i} <= 3'b000;
      repeat (4) @(posedge c);
      rst_n_i <= 1;
      repeat (3) @(posedge c);
      chk("att", 12'h000, att);
   endtask
   task automatic t_load();
      logic [7:0] t [4] = '{8'hff, 8'h00, 8'h3c, 8'hc9};
      for (int i = 0; i < 4; i++) begin
         word_order_sel_i <= (i < 2);
         u_host.shift_word(t[i]);
         for (int k = 0; k < 6; k++) e[k] = (i < 2) ? t[i][k] : t[i][7 - k];
         u_host.latch(1, 0);
         chk("att", {p, e}, att);
         if (i == 1) chk("sdo", t[0][0], ser_data_out_o);
         u_host.latch(0, 1);
         p = e;
         chk("att", {p, e}, att);
      end
   endtask
   task automatic t_both();
      u_host.shift_word(8'h96);
      u_host.latch(1, 1);
      wb(0, 4'h0, 0);
      chk("status", 32'h2929, rd);
      wb(0, 4'h8, 0);
      chk("shift", 32'h69, rd);
      wb(1, 4'h4, 1);
      chk("forced", 12'hfff, att);
      wb(0, 4'hc, 0);
      chk("unmapped", 0, rd);
   endtask
   initial forever #10 c = ~c;
   initial begin
      repeat (12) @(posedge c);
      rst_n_i <= 1;
      repeat (3) @(posedge c);
      t_init();
      t_load();
      t_both();
      complete_run();
   end
   initial begin #400000; errors++; complete_run(); end
endmodule
`default_nettype wire
